// File: rtl/hmfs_regs.svh
// Purpose: Register map, field positions and reset values of the host MAC FIFO status and CSR port
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef HMFS_REGS_SVH
`define HMFS_REGS_SVH
`define HMFS_ADDR_TX_FIFO_INFO  12'h0080
`define HMFS_ADDR_DROP_COUNT    12'h00a0
`define HMFS_ADDR_CSR_COMMAND   12'h00a4
`define HMFS_ADDR_CSR_VALUE     12'h00a8
`define HMFS_TX_FREE_RESET      16'h1200
`define HMFS_TALLY_HALF_FROM    32'h7fff_ffff
`define HMFS_TALLY_HALF_TO      32'h8000_0000
`define HMFS_BUSY_BIT           31
`define HMFS_DIR_BIT            30
`define HMFS_INDEX_MSB          7
`define HMFS_STS_USED_LSB       16
`define HMFS_STS_USED_MSB       23
`define HMFS_FREE_MSB           15
`define HMFS_ZERO32             32'h0000_0000
`define HMFS_ZERO8              8'h00
`define HMFS_ONE32              32'h0000_0001
`define HMFS_ZERO22             22'h00_0000
`define HMFS_INFO_RSVD_MSB      31
`define HMFS_INFO_RSVD_LSB      24
`define HMFS_CMD_RSVD_MSB       29
`define HMFS_CMD_RSVD_LSB       8
`endif

// File: rtl/hmfs_pkg.sv
// Purpose: Types of the host MAC FIFO status and CSR port
// Assumes: Nothing beyond the register header
// Notes:   Whole state lives in one packed struct
package hmfs_pkg;
  typedef enum logic [1:0] {
    HMFS_IDLE,
    HMFS_ISSUE,
    HMFS_WAIT
  } hmfs_state_t;

  typedef struct packed {
    hmfs_state_t  state;
    logic [31:0]  drop_tally;
    logic         cmd_busy;
    logic         cmd_dir;
    logic [7:0]   cmd_index;
    logic [31:0]  value_wr;
    logic [31:0]  value_rd;
    logic         csr_req;
    logic         csr_we;
    logic [7:0]   csr_addr;
    logic [31:0]  csr_wdata;
    logic         half_event;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [7:0]   sts_used;
    logic [15:0]  data_free;
  } hmfs_st_t;
endpackage

// File: rtl/hmfs_csr_port.sv
// Function
// [R1] Status FIFO occupied words reported in bits 23:16, read-only, reset zero.
// [R2] Data FIFO free bytes in bits 15:0, read-only, reset 1200h.
// [R3] Software never pushes more bytes than the free field shows.
// [R4] 32-bit counter increments once per dropped receive frame.
// [R5] Reading the drop counter returns the count then clears it.
// [R6] Counter stepping 7FFFFFFFh to 80000000h pulses the halfway event.
// [R7] Writing one to bit 31 starts an indirect internal register access.
// [R8] Busy stays set until access finishes; clearing marks read data valid.
// [R9] Software leaves command and data alone while busy reads one.
// [R10] Bit 30 picks direction: one reads, zero writes; resets zero.
// [R11] Bits 7:0 hold the internal register index, read/write, reset zero.
// [R12] Data register carries the value; a write access sends it out.
// [R13] Data read returns internal value if direction is one, else last written.
// [R14] Reserved bits read zero; access latency is finite and ends busy.
//
// Purpose: APB register bank for TX FIFO levels, drop tally and indirect CSR port
// Assumes: All inputs synchronous to sys_clk_i; internal CSR answers with csr_ack_i
// Notes:   APB answers in the access cycle (pready one cycle after setup)
`timescale 1ns/1ns
`include "hmfs_regs.svh"
module hmfs_csr_port
  import hmfs_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // FIFO levels and drop events from the MAC, drop tally halfway event out
  input  wire logic [7:0]  tx_status_words_used_i,
  input  wire logic [15:0] tx_data_bytes_free_i,
  input  wire logic        rx_frame_dropped_i,
  output logic             drop_tally_half_event_o,
  // Internal MAC CSR space
  output logic             csr_req_o,
  output logic             csr_we_o,
  output logic      [7:0]  csr_addr_o,
  output logic      [31:0] csr_wdata_o,
  input  wire logic        csr_ack_i,
  input  wire logic [31:0] csr_rdata_i
);

  hmfs_st_t st_reg;
  hmfs_st_t st_next;
  logic     setup;
  logic     rd_drop;

  // One decode function, called for rd_drop, the read mux and the write path
  function automatic logic [2:0] hmfs_decode(input logic [11:0] a);
    case (a)
      `HMFS_ADDR_TX_FIFO_INFO: hmfs_decode = 3'h1;
      `HMFS_ADDR_DROP_COUNT:   hmfs_decode = 3'h2;
      `HMFS_ADDR_CSR_COMMAND:  hmfs_decode = 3'h3;
      `HMFS_ADDR_CSR_VALUE:    hmfs_decode = 3'h4;
      default:                 hmfs_decode = 3'h0;
    endcase
  endfunction

  assign setup   = psel_i && !penable_i;
  assign rd_drop = setup && !pwrite_i && (hmfs_decode(paddr_i) == 3'h2);

  always_comb begin
    st_next            = st_reg;
    st_next.pready     = 1'b0;
    st_next.pslverr    = 1'b0;
    st_next.csr_req    = 1'b0;
    st_next.half_event = 1'b0;
    st_next.prdata     = `HMFS_ZERO32;
    // The MAC must show 1200h here while its data FIFO is empty
    st_next.sts_used   = tx_status_words_used_i;                     // [R1]
    st_next.data_free  = tx_data_bytes_free_i;                       // [R2]

    // Read clears, but a drop in the same cycle is kept as one [R5]
    if (rd_drop) begin
      st_next.drop_tally = {31'h0000_0000, rx_frame_dropped_i};  // [R5]
    end else if (rx_frame_dropped_i) begin
      st_next.drop_tally = st_reg.drop_tally + `HMFS_ONE32;      // [R4]
    end
    if (rx_frame_dropped_i && !rd_drop && st_reg.drop_tally == `HMFS_TALLY_HALF_FROM) begin
      st_next.half_event = 1'b1;                                 // [R6]
    end

    if (setup) begin
      st_next.pready = 1'b1;
      if (!pwrite_i) begin
        case (hmfs_decode(paddr_i))
          3'h1: st_next.prdata = {`HMFS_ZERO8, st_reg.sts_used, st_reg.data_free};  // [R1] [R2] [R14]
          3'h2: st_next.prdata = st_reg.drop_tally;                     // [R5]
          3'h3: st_next.prdata = {st_reg.cmd_busy, st_reg.cmd_dir, `HMFS_ZERO22,
                                  st_reg.cmd_index};                    // [R14]
          3'h4: st_next.prdata = st_reg.cmd_dir ? st_reg.value_rd : st_reg.value_wr;  // [R13]
          default: st_next.pslverr = 1'b1;
        endcase
      end else begin
        case (hmfs_decode(paddr_i))
          3'h3: begin
            // Command is frozen while busy; software must wait anyway [R9]
            if (!st_reg.cmd_busy) begin
              st_next.cmd_dir   = pwdata_i[`HMFS_DIR_BIT];              // [R10]
              st_next.cmd_index = pwdata_i[`HMFS_INDEX_MSB:0];          // [R11]
              st_next.cmd_busy  = pwdata_i[`HMFS_BUSY_BIT];             // [R7]
            end
          end
          3'h4: begin
            if (!st_reg.cmd_busy) begin
              st_next.value_wr = pwdata_i;                              // [R12] [R9]
            end
          end
          3'h1, 3'h2: st_next.pslverr = 1'b0;
          default: st_next.pslverr = 1'b1;
        endcase
      end
    end

    case (st_reg.state)
      HMFS_IDLE: begin
        if (st_reg.cmd_busy) begin
          st_next.state = HMFS_ISSUE;                                   // [R7]
        end
      end
      HMFS_ISSUE: begin
        st_next.csr_req   = 1'b1;
        st_next.csr_we    = !st_reg.cmd_dir;                            // [R10]
        st_next.csr_addr  = st_reg.cmd_index;                           // [R11]
        st_next.csr_wdata = st_reg.value_wr;                            // [R12]
        st_next.state     = HMFS_WAIT;
      end
      HMFS_WAIT: begin
        st_next.csr_req = 1'b1;
        if (csr_ack_i) begin
          st_next.csr_req  = 1'b0;
          if (st_reg.cmd_dir) begin
            st_next.value_rd = csr_rdata_i;                             // [R13]
          end
          st_next.cmd_busy = 1'b0;                                      // [R8] [R14]
          st_next.state    = HMFS_IDLE;
        end
      end
      default: st_next.state = HMFS_IDLE;
    endcase

    // Reset taken last so it overrides every update above
    if (rst_i) begin
      st_next           = '0;                                          // [R1] [R10] [R11]
      st_next.data_free = `HMFS_TX_FREE_RESET;                         // [R2]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st_reg <= st_next;
  end

  assign prdata_o                = st_reg.prdata;
  assign pready_o                = st_reg.pready;
  assign pslverr_o               = st_reg.pslverr;
  assign drop_tally_half_event_o = st_reg.half_event;
  assign csr_req_o               = st_reg.csr_req;
  assign csr_we_o                = st_reg.csr_we;
  assign csr_addr_o              = st_reg.csr_addr;
  assign csr_wdata_o             = st_reg.csr_wdata;

  property p_half_event;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_frame_dropped_i && !rd_drop && st_reg.drop_tally == `HMFS_TALLY_HALF_FROM)
        |=> (drop_tally_half_event_o && st_reg.drop_tally == `HMFS_TALLY_HALF_TO);
  endproperty
  a_half_event: assert property (p_half_event) else $error("halfway event missing");  // [R6]

  property p_drop_inc;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_frame_dropped_i && !rd_drop) |=> st_reg.drop_tally == $past(st_reg.drop_tally) + `HMFS_ONE32;
  endproperty
  a_drop_inc: assert property (p_drop_inc) else $error("drop tally not incremented");  // [R4]

  property p_read_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rd_drop && !rx_frame_dropped_i) |=> (pready_o && prdata_o == $past(st_reg.drop_tally)
                                            && st_reg.drop_tally == `HMFS_ZERO32);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("drop read did not clear");  // [R5]

  property p_start;
    @(posedge sys_clk_i) disable iff (rst_i)
      (setup && pwrite_i && paddr_i == `HMFS_ADDR_CSR_COMMAND && !st_reg.cmd_busy
       && pwdata_i[`HMFS_BUSY_BIT]) |=> ##2 (csr_req_o
       && csr_addr_o == $past(pwdata_i[`HMFS_INDEX_MSB:0], 3)
       && csr_we_o == !$past(pwdata_i[`HMFS_DIR_BIT], 3));
  endproperty
  a_start: assert property (p_start) else $error("access not started");  // [R7]

  property p_dir;
    @(posedge sys_clk_i) disable iff (rst_i)
      csr_req_o |-> (csr_we_o == !st_reg.cmd_dir && csr_addr_o == st_reg.cmd_index);
  endproperty
  a_dir: assert property (p_dir) else $error("direction or index wrong");  // [R10]

  property p_busy_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st_reg.state == HMFS_WAIT && csr_ack_i) |=> (!st_reg.cmd_busy && !csr_req_o);
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy did not clear");  // [R8]

  property p_busy_held;
    @(posedge sys_clk_i) disable iff (rst_i)
      (csr_req_o && !csr_ack_i) |-> st_reg.cmd_busy;
  endproperty
  a_busy_held: assert property (p_busy_held) else $error("busy dropped early");  // [R8]

  property p_rd_data;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st_reg.state == HMFS_WAIT && csr_ack_i && st_reg.cmd_dir) |=> st_reg.value_rd == $past(csr_rdata_i);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not captured");  // [R13]

  property p_wr_data;
    @(posedge sys_clk_i) disable iff (rst_i)
      (csr_req_o && csr_we_o) |-> csr_wdata_o == st_reg.value_wr;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data mismatch");  // [R12]

  property p_info;
    @(posedge sys_clk_i) disable iff (rst_i)
      (setup && !pwrite_i && paddr_i == `HMFS_ADDR_TX_FIFO_INFO)
        |=> (prdata_o[`HMFS_INFO_RSVD_MSB:`HMFS_INFO_RSVD_LSB] == `HMFS_ZERO8
             && prdata_o[`HMFS_FREE_MSB:0] == $past(st_reg.data_free)
             && prdata_o[`HMFS_STS_USED_MSB:`HMFS_STS_USED_LSB] == $past(st_reg.sts_used));
  endproperty
  a_info: assert property (p_info) else $error("fifo info read wrong");  // [R1]

  property p_info_write_ok;
    @(posedge sys_clk_i) disable iff (rst_i)
      (setup && pwrite_i && paddr_i == `HMFS_ADDR_TX_FIFO_INFO) |=> (pready_o && !pslverr_o);
  endproperty
  a_info_write_ok: assert property (p_info_write_ok) else $error("info write answered wrongly");  // [R1]

  property p_busy_set;
    @(posedge sys_clk_i) disable iff (rst_i)
      (setup && pwrite_i && paddr_i == `HMFS_ADDR_CSR_COMMAND && !st_reg.cmd_busy && pwdata_i[`HMFS_BUSY_BIT])
        |=> st_reg.cmd_busy;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set by command write");  // [R7]

  // Issue latency is fixed, so a stuck state machine shows up here
  property p_latency;
    @(posedge sys_clk_i) disable iff (rst_i)
      $rose(st_reg.cmd_busy) |-> ##2 csr_req_o;
  endproperty
  a_latency: assert property (p_latency) else $error("indirect access not issued");  // [R14]

  // Writes while busy are dropped rather than queued
  property p_cmd_frozen;
    @(posedge sys_clk_i) disable iff (rst_i)
      (setup && pwrite_i && st_reg.cmd_busy)
        |=> (st_reg.cmd_index == $past(st_reg.cmd_index)
             && st_reg.cmd_dir == $past(st_reg.cmd_dir)
             && st_reg.value_wr == $past(st_reg.value_wr));
  endproperty
  a_cmd_frozen: assert property (p_cmd_frozen) else $error("command changed while busy");  // [R9]

  property p_cmd_readback;
    @(posedge sys_clk_i) disable iff (rst_i)
      (setup && !pwrite_i && paddr_i == `HMFS_ADDR_CSR_COMMAND)
        |=> (prdata_o[`HMFS_INDEX_MSB:0] == $past(st_reg.cmd_index)
             && prdata_o[`HMFS_DIR_BIT] == $past(st_reg.cmd_dir)
             && prdata_o[`HMFS_BUSY_BIT] == $past(st_reg.cmd_busy)
             && prdata_o[`HMFS_CMD_RSVD_MSB:`HMFS_CMD_RSVD_LSB] == `HMFS_ZERO22);
  endproperty
  a_cmd_readback: assert property (p_cmd_readback) else $error("command readback wrong");  // [R11]

  property p_value_read;
    @(posedge sys_clk_i) disable iff (rst_i)
      (setup && !pwrite_i && paddr_i == `HMFS_ADDR_CSR_VALUE)
        |=> prdata_o == ($past(st_reg.cmd_dir) ? $past(st_reg.value_rd) : $past(st_reg.value_wr));
  endproperty
  a_value_read: assert property (p_value_read) else $error("data register read wrong");  // [R13]

  property p_drop_and_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rd_drop && rx_frame_dropped_i) |=> st_reg.drop_tally == `HMFS_ONE32;
  endproperty
  a_drop_and_clear: assert property (p_drop_and_clear) else $error("drop lost during clear");  // [R5]

  property p_half_only;
    @(posedge sys_clk_i) disable iff (rst_i)
      drop_tally_half_event_o |-> st_reg.drop_tally == `HMFS_TALLY_HALF_TO;
  endproperty
  a_half_only: assert property (p_half_only) else $error("stray halfway event");  // [R6]

  property p_pready_after_setup;
    @(posedge sys_clk_i) disable iff (rst_i)
      setup |=> pready_o;
  endproperty
  a_pready_after_setup: assert property (p_pready_after_setup) else $error("no ready after setup");  // [R14]

  property p_pready_only_after_setup;
    @(posedge sys_clk_i) disable iff (rst_i)
      !setup |=> !pready_o;
  endproperty
  a_pready_only_after_setup: assert property (p_pready_only_after_setup) else $error("stray ready");  // [R14]

  property p_slverr;
    @(posedge sys_clk_i) disable iff (rst_i)
      (setup && hmfs_decode(paddr_i) == 3'h0) |=> (pslverr_o && prdata_o == `HMFS_ZERO32);
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");  // [R14]

endmodule

// File: testbench/tb.sv
// Purpose: Self-checking bench of the FIFO status and indirect CSR port
// Assumes: Bench plays both the APB master and the internal CSR space
// Notes:   Half event needs 2^31 drops, so only the design assertion covers it
`timescale 1ns/1ns
`include "hmfs_regs.svh"
module tb import hmfs_pkg::*;;
  localparam logic [11:0] a_info = `HMFS_ADDR_TX_FIFO_INFO;
  localparam logic [11:0] a_drop = `HMFS_ADDR_DROP_COUNT;
  localparam logic [11:0] a_cmd  = `HMFS_ADDR_CSR_COMMAND;
  localparam logic [11:0] a_val  = `HMFS_ADDR_CSR_VALUE;
  // Design inputs
  logic        sys_clk_i              = 1'b0;
  logic        rst_i                  = 1'b1;
  logic        psel_i                 = 1'b0;
  logic        penable_i              = 1'b0;
  logic        pwrite_i               = 1'b0;
  logic [11:0] paddr_i                = 12'h000;
  logic [31:0] pwdata_i               = 32'h0000_0000;
  logic [7:0]  tx_status_words_used_i = 8'h00;
  logic [15:0] tx_data_bytes_free_i   = 16'h1200;
  logic        rx_frame_dropped_i     = 1'b0;
  logic        csr_ack_i              = 1'b0;
  logic [31:0] csr_rdata_i            = 32'hffff_ffff;
  // Design outputs
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        drop_tally_half_event_o;
  logic        csr_req_o;
  logic        csr_we_o;
  logic [7:0]  csr_addr_o;
  logic [31:0] csr_wdata_o;
  int          errors = 0;
  int          checks = 0;
  logic [31:0] q;
  logic        e;

  always #20 sys_clk_i = ~sys_clk_i;

  hmfs_csr_port i_hmfs_csr_port (
    .sys_clk_i               (sys_clk_i),
    .rst_i                   (rst_i),
    .psel_i                  (psel_i),
    .penable_i               (penable_i),
    .pwrite_i                (pwrite_i),
    .paddr_i                 (paddr_i),
    .pwdata_i                (pwdata_i),
    .prdata_o                (prdata_o),
    .pready_o                (pready_o),
    .pslverr_o               (pslverr_o),
    .tx_status_words_used_i  (tx_status_words_used_i),
    .tx_data_bytes_free_i    (tx_data_bytes_free_i),
    .rx_frame_dropped_i      (rx_frame_dropped_i),
    .drop_tally_half_event_o (drop_tally_half_event_o),
    .csr_req_o               (csr_req_o),
    .csr_we_o                (csr_we_o),
    .csr_addr_o              (csr_addr_o),
    .csr_wdata_o             (csr_wdata_o),
    .csr_ack_i               (csr_ack_i),
    .csr_rdata_i             (csr_rdata_i)
  );

  task automatic final_report;
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tmo;
    errors++;
    $display("Error at %0t: no answer", $time);
    final_report();
  endtask

  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    q = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Internal CSR space: waits for the request, acks once, then scrambles data
  task automatic serve(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] rd);
    int n;
    n = 0;
    while (csr_req_o !== 1'b1 && n < 20) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 20) tmo();
    chk({31'h0, csr_we_o}, {31'h0, w});
    chk({24'h0, csr_addr_o}, {24'h0, a});
    if (w) chk(csr_wdata_o, wd);
    csr_ack_i   <= 1'b1;
    csr_rdata_i <= rd;
    @(posedge sys_clk_i);
    csr_ack_i   <= 1'b0;
    csr_rdata_i <= ~rd;
    @(posedge sys_clk_i);
    chk({31'h0, csr_req_o}, 32'h0000_0000);
  endtask

  task automatic t_info;
    apb(1'b0, a_info, 32'h0);
    chk(q, 32'h0000_1200);
    tx_status_words_used_i <= 8'hff;
    tx_data_bytes_free_i   <= 16'h0040;
    apb(1'b1, a_info, 32'hffff_ffff);
    chk({31'h0, e}, 32'h0000_0000);
    apb(1'b0, a_info, 32'h0);
    chk(q, 32'h00ff_0040);
  endtask

  task automatic t_drop;
    rx_frame_dropped_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rx_frame_dropped_i <= 1'b0;
    apb(1'b0, a_drop, 32'h0);
    chk(q, 32'h0000_0003);
    apb(1'b0, a_drop, 32'h0);
    chk(q, 32'h0000_0000);
    // Drop lands in the very setup cycle of the clearing read
    fork
      apb(1'b0, a_drop, 32'h0);
      begin
        @(posedge sys_clk_i);
        rx_frame_dropped_i <= 1'b1;
        @(posedge sys_clk_i);
        rx_frame_dropped_i <= 1'b0;
      end
    join
    chk(q, 32'h0000_0000);
    apb(1'b0, a_drop, 32'h0);
    chk(q, 32'h0000_0001);
    chk({31'h0, drop_tally_half_event_o}, 32'h0000_0000);
  endtask

  task automatic t_write;
    apb(1'b1, a_val, 32'hcafe_0001);
    apb(1'b1, a_cmd, 32'h8000_0005);
    apb(1'b0, a_cmd, 32'h0);
    chk(q, 32'h8000_0005);
    // Late data write must not reach the target
    apb(1'b1, a_val, 32'h1234_5678);
    serve(1'b1, 8'h05, 32'hcafe_0001, 32'h0);
    apb(1'b0, a_cmd, 32'h0);
    chk(q, 32'h0000_0005);
    apb(1'b0, a_val, 32'h0);
    chk(q, 32'hcafe_0001);
  endtask

  task automatic t_read;
    apb(1'b1, a_cmd, 32'hc000_00ff);
    serve(1'b0, 8'hff, 32'h0, 32'h5a5a_a5a5);
    apb(1'b0, a_cmd, 32'h0);
    chk(q, 32'h4000_00ff);
    apb(1'b0, a_val, 32'h0);
    chk(q, 32'h5a5a_a5a5);
  endtask

  task automatic t_misc;
    apb(1'b1, a_cmd, 32'h3fff_ff12);
    apb(1'b0, a_cmd, 32'h0);
    chk(q, 32'h0000_0012);
    chk({31'h0, csr_req_o}, 32'h0000_0000);
    apb(1'b0, 12'h0b0, 32'h0);
    chk({31'h0, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_info();
    t_drop();
    t_misc();
    t_write();
    t_read();
    final_report();
  end
endmodule
